//--- tdnv_pkg.sv
// Constants for the table-read and data EEPROM access block.
// Assumes a single pclk domain and an APB register bus of 32-bit words.
package tdnv_pkg;
    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] TDNV_OFF_TABLE_POINTER   = 8'h00;
    localparam logic [7:0] TDNV_OFF_TBLAT    = 8'h04;
    localparam logic [7:0] TDNV_OFF_TBLCMD   = 8'h08;
    localparam logic [7:0] TDNV_OFF_CTRL     = 8'h0C;
    localparam logic [7:0] TDNV_OFF_UNLOCK   = 8'h10;
    localparam logic [7:0] TDNV_OFF_ADDR_LO  = 8'h14;
    localparam logic [7:0] TDNV_OFF_ADDR_HI  = 8'h18;
    localparam logic [7:0] TDNV_OFF_DATA     = 8'h1C;
    localparam logic [7:0] TDNV_OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] TDNV_OFF_IRQ_CLR  = 8'h24;
    localparam logic [7:0] TDNV_OFF_IRQ_EN   = 8'h28;
    // ****************************************
    // Control register fields
    // ****************************************
    localparam int TDNV_BIT_RD     = 0;
    localparam int TDNV_BIT_WR     = 1;
    localparam int TDNV_BIT_WRITE_ENABLE_BIT   = 2;
    localparam int TDNV_BIT_CFGSEL = 6;
    localparam int TDNV_BIT_PMSEL  = 7;
    // Table command fields: bit 0 go, bits 2:1 pointer mode
    localparam int TDNV_BIT_TGO    = 0;
    localparam int TDNV_BIT_TMODE  = 1;
    localparam logic [1:0] TDNV_TM_NONE = 2'h0;
    localparam logic [1:0] TDNV_TM_POST_INC = 2'h1;
    localparam logic [1:0] TDNV_TM_POST_DEC = 2'h2;
    localparam logic [1:0] TDNV_TM_PRE_INC = 2'h3;
    // ****************************************
    // Unlock keys, reset values and timing
    // ****************************************
    localparam logic [7:0] TDNV_KEY1       = 8'h55;
    localparam logic [7:0] TDNV_KEY2       = 8'hAA;
    localparam logic [7:0] TDNV_CTRL_RST   = 8'h00;
    localparam int         TDNV_CLK_MHZ    = 50;
    localparam int         TDNV_WRITE_US   = 4;
    localparam int         TDNV_WRITE_CYC  = TDNV_WRITE_US * TDNV_CLK_MHZ;
    localparam logic [31:0] TDNV_ZERO32    = 32'h0000_0000;
endpackage

//--- tdnv_mem.sv
// Small byte memory standing in for one storage array.
// Assumes synchronous read and write on pclk; read data come from a register.
`timescale 1ns/10ps
module tdnv_mem
    import tdnv_pkg::*;
#(
    parameter int AW = 10
)
(
    input  wire logic          pclk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output logic      [7:0]    rdata_ff
);
    logic [7:0] mem [0:(1<<AW)-1];

    // ****************************************
    // Storage; no reset so contents survive like real cells
    // ****************************************
    // Plain clocked process so a loader may preset the cells
    always @(posedge pclk)
    begin
        if (ce && we)
            mem[addr] <= wdata;
    end

    // Read data register
    always_ff @(posedge pclk)
    begin
        if (ce)
            rdata_ff <= mem[addr];
    end
endmodule

//--- tdnv_unlock.sv
// Two-key unlock detector for the EEPROM write start.
// Assumes key writes arrive as one-cycle strobes from the register decode.
`timescale 1ns/10ps
module tdnv_unlock
    import tdnv_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    input  wire logic       key_wr,
    input  wire logic [7:0] key_data,
    input  wire logic       other_wr,
    input  wire logic       consume,
    output logic            armed
);
    typedef enum logic [1:0] {TDNV_U_IDLE, TDNV_U_ONE, TDNV_U_ARMED} tdnv_ust_t;
    typedef struct packed { tdnv_ust_t st; } tdnv_ustate_t;
    tdnv_ustate_t s_ff;
    tdnv_ustate_t nxt_s;

    // ****************************************
    // Sequence: 55h then AAh then start; any other write breaks it
    // ****************************************
    always_comb
    begin
        nxt_s = s_ff;
        case (s_ff.st)
            TDNV_U_IDLE:
                if (key_wr && key_data == TDNV_KEY1)
                    nxt_s.st = TDNV_U_ONE;
            TDNV_U_ONE:
                if (key_wr && key_data == TDNV_KEY2)
                    nxt_s.st = TDNV_U_ARMED;
                else if (key_wr || other_wr)
                    nxt_s.st = TDNV_U_IDLE;
            default:
                if (key_wr || other_wr || consume)
                    nxt_s.st = TDNV_U_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_ff <= '{st: TDNV_U_IDLE};
        else if (ce)
            s_ff <= nxt_s;
    end

    // Key values are never stored, only matched
    assign armed = (s_ff.st == TDNV_U_ARMED);
endmodule

//--- tdnv_top.sv
// Table-read and data EEPROM access block with APB register slave.
// Assumes one pclk domain; program flash and EEPROM arrays are modelled inside.
//
// Behaviour
// - Table read moves one byte per operation
// - Read byte at pointer into latch, adjust
// - Each pointer value addresses one byte of the flash array
// - EEPROM byte appears in data register next cycle
// - Data register held until read or write
// - Write starts only after 55h, AAh, start
// - Write start blocked unless enable already set
// - Enable and start together do not start
// - Hardware never clears the write enable
// - Control, address and data registers locked while write in progress
// - Completion clears start and sets done flag
// - Done flag sticks until software clears it
// - Unlock port stores nothing
`timescale 1ns/10ps
module tdnv_top
    import tdnv_pkg::*;
#(
    parameter int PM_AW     = 12,
    parameter int EE_AW     = 10,
    parameter int WRITE_CYC = TDNV_WRITE_CYC
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    // Pointer is 22 bits and the write counter 16 bits, so larger
    // arrays or longer write times cannot be served
    if (PM_AW < 2 || PM_AW > 21 || EE_AW < 1 || EE_AW > 16 || WRITE_CYC < 1
        || WRITE_CYC > 65535)
        $error("tdnv_top: parameter out of range");

    typedef enum logic [1:0] {TDNV_S_IDLE, TDNV_S_TBL, TDNV_S_EERD, TDNV_S_EEWR} tdnv_st_t;

    // One packed struct holds every register of the block except the pointer mode register
    typedef struct packed {
        tdnv_st_t    st;
        logic [21:0] table_pointer;
        logic [7:0]  table_latch;
        logic [7:0]  eeprom_control;
        logic [7:0]  eeprom_addr_low;
        logic [7:0]  eeprom_addr_high;
        logic [7:0]  eeprom_data_reg;
        logic        eeprom_done_flag;
        logic        irq_en;
        logic [15:0] wcnt;
        logic [31:0] rdata;
        logic        ack;
        logic        err;
    } tdnv_state_t;

    tdnv_state_t s_ff;
    tdnv_state_t nxt_s;

    // Memory and unlock wires
    logic [7:0]       pm_rdata;
    logic [7:0]       ee_rdata;
    logic             armed;
    logic             pm_we_unused;
    logic [EE_AW-1:0] ee_addr;
    logic [PM_AW-1:0] pm_addr;
    logic             ee_we;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] wbyte(input logic [31:0] d, input logic [3:0] s,
                                         input logic [7:0] old);
        wbyte = s[0] ? d[7:0] : old;
    endfunction

    function automatic logic [21:0] ptr_step(input logic [21:0] p, input logic [1:0] m);
        case (m)
            TDNV_TM_POST_INC, TDNV_TM_PRE_INC: ptr_step = p + 22'h000001;
            TDNV_TM_POST_DEC:                  ptr_step = p - 22'h000001;
            default:                           ptr_step = p;
        endcase
    endfunction

    // ****************************************
    // APB strobes; slave answers one cycle after the access starts
    // ****************************************
    logic acc;
    logic wr_acc;
    logic busy;
    // Answer pulse blocks a second take in one access phase
    assign acc    = psel && penable && !s_ff.ack;
    assign wr_acc = acc && pwrite;
    assign busy   = (s_ff.st == TDNV_S_EEWR);
    assign pready  = s_ff.ack;
    assign pslverr = s_ff.err;
    assign prdata  = s_ff.rdata;
    assign irq     = s_ff.eeprom_done_flag && s_ff.irq_en;

    // Address into the arrays; table byte addressing, byte in array
    // Flash address follows the next pointer so a pre-increment is
    // already in the array register when the fetch state samples it
    assign pm_addr = nxt_s.table_pointer[PM_AW-1:0];
    assign ee_addr = EE_AW'({s_ff.eeprom_addr_high, s_ff.eeprom_addr_low});
    // Cell written in the last cycle of the write time, on the same
    // edge that raises the done flag
    assign ee_we   = (s_ff.st == TDNV_S_EEWR) && (s_ff.wcnt == 16'h0001);
    assign pm_we_unused = 1'b0;

    // ****************************************
    // Unlock detector; key port writes feed it only
    // ****************************************
    tdnv_unlock u_unlock (
        .pclk     (pclk),
        .presetn  (presetn),
        .ce       (clk_en),
        .key_wr   (wr_acc && paddr == TDNV_OFF_UNLOCK && !busy),
        .key_data (pwdata[7:0]),
        .other_wr (wr_acc && paddr != TDNV_OFF_UNLOCK),
        .consume  (1'b0),
        .armed    (armed)
    );

    // ****************************************
    // Storage arrays: program flash is a byte image, EEPROM a byte array
    // ****************************************
    tdnv_mem #(.AW(PM_AW)) u_pm (
        .pclk     (pclk),
        .ce       (clk_en),
        .we       (pm_we_unused),
        .addr     (pm_addr),
        .wdata    (8'h00),
        .rdata_ff (pm_rdata)
    );

    tdnv_mem #(.AW(EE_AW)) u_ee (
        .pclk     (pclk),
        .ce       (clk_en),
        .we       (ee_we),
        .addr     (ee_addr),
        .wdata    (s_ff.eeprom_data_reg),
        .rdata_ff (ee_rdata)
    );

    // ****************************************
    // Pointer mode register
    // ****************************************
    // Kept apart so the post-adjust sees the mode of the command
    // that started the fetch
    logic [1:0] tbl_mode_ff;
    logic [1:0] nxt_tbl_mode;
    assign nxt_tbl_mode = (wr_acc && paddr == TDNV_OFF_TBLCMD && pstrb[0])
                          ? pwdata[TDNV_BIT_TMODE +: 2] : tbl_mode_ff;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        logic [7:0] cw;
        logic [1:0] tm;
        cw    = 8'h00;
        tm    = 2'h0;
        nxt_s = s_ff;
        nxt_s.ack   = 1'b0;
        nxt_s.err   = 1'b0;
        nxt_s.rdata = TDNV_ZERO32;

        // Sequencer: memory reads take one cycle through the array register
        case (s_ff.st)
            TDNV_S_TBL:
            begin
                nxt_s.table_latch = pm_rdata;
                nxt_s.st = TDNV_S_IDLE;
            end
            TDNV_S_EERD:
            begin
                nxt_s.eeprom_data_reg = ee_rdata;
                nxt_s.eeprom_control[TDNV_BIT_RD] = 1'b0;
                nxt_s.st = TDNV_S_IDLE;
            end
            TDNV_S_EEWR:
            begin
                if (s_ff.wcnt == 16'h0001)
                begin
                    nxt_s.eeprom_control[TDNV_BIT_WR] = 1'b0;
                    nxt_s.eeprom_done_flag = 1'b1;
                    nxt_s.st = TDNV_S_IDLE;
                end
                nxt_s.wcnt = s_ff.wcnt - 16'h0001;
            end
            default: ;
        endcase

        // Register access
        if (acc)
        begin
            nxt_s.ack = 1'b1;
            if (pwrite)
            begin
                if (paddr == TDNV_OFF_TABLE_POINTER)
                begin
                    nxt_s.table_pointer = pstrb[0] ? pwdata[21:0] : s_ff.table_pointer;
                end
                else if (paddr == TDNV_OFF_TBLCMD)
                begin
                    tm = pwdata[TDNV_BIT_TMODE +: 2];
                    // Go is ignored while another operation is in flight
                    if (pstrb[0] && pwdata[TDNV_BIT_TGO] && s_ff.st == TDNV_S_IDLE)
                    begin
                        // Pre-increment moves before the fetch, post-increment and post-decrement after
                        if (tm == TDNV_TM_PRE_INC)
                            nxt_s.table_pointer = ptr_step(s_ff.table_pointer, tm);
                        nxt_s.st = TDNV_S_TBL;
                    end
                end
                else if (paddr == TDNV_OFF_CTRL)
                begin
                    cw = wbyte(pwdata, pstrb, s_ff.eeprom_control);
                    if (!busy)
                    begin
                        nxt_s.eeprom_control[TDNV_BIT_PMSEL]  = cw[TDNV_BIT_PMSEL];
                        nxt_s.eeprom_control[TDNV_BIT_CFGSEL] = cw[TDNV_BIT_CFGSEL];
                        nxt_s.eeprom_control[TDNV_BIT_WRITE_ENABLE_BIT]   = cw[TDNV_BIT_WRITE_ENABLE_BIT];
                        // Read start wins when both starts come in one write with PMSEL and CFGSEL clear
                        if (cw[TDNV_BIT_RD] && !cw[TDNV_BIT_PMSEL] && !cw[TDNV_BIT_CFGSEL])
                        begin
                            nxt_s.eeprom_control[TDNV_BIT_RD] = 1'b1;
                            nxt_s.st = TDNV_S_EERD;
                        end
                        // Start needs enable from an earlier write and the keys
                        else if (cw[TDNV_BIT_WR] && s_ff.eeprom_control[TDNV_BIT_WRITE_ENABLE_BIT]
                                 && armed && !cw[TDNV_BIT_PMSEL])
                        begin
                            nxt_s.eeprom_control[TDNV_BIT_WR] = 1'b1;
                            nxt_s.wcnt = 16'(WRITE_CYC);
                            nxt_s.st = TDNV_S_EEWR;
                        end
                    end
                end
                else if (paddr == TDNV_OFF_UNLOCK)
                begin
                    // Nothing stored behind the key port
                end
                else if (paddr == TDNV_OFF_ADDR_LO)
                begin
                    if (!busy)
                        nxt_s.eeprom_addr_low = wbyte(pwdata, pstrb, s_ff.eeprom_addr_low);
                end
                else if (paddr == TDNV_OFF_ADDR_HI)
                begin
                    if (!busy)
                        nxt_s.eeprom_addr_high = wbyte(pwdata, pstrb, s_ff.eeprom_addr_high);
                end
                else if (paddr == TDNV_OFF_DATA)
                begin
                    if (!busy && s_ff.st != TDNV_S_EERD)
                        nxt_s.eeprom_data_reg = wbyte(pwdata, pstrb, s_ff.eeprom_data_reg);
                end
                else if (paddr == TDNV_OFF_IRQ_CLR)
                begin
                    // Clear loses to a completion in the same cycle
                    if (pstrb[0] && pwdata[0] && !nxt_s.eeprom_done_flag)
                        nxt_s.eeprom_done_flag = 1'b0;
                    else if (pstrb[0] && pwdata[0] && s_ff.eeprom_done_flag
                             && !(s_ff.st == TDNV_S_EEWR && s_ff.wcnt == 16'h0001))
                        nxt_s.eeprom_done_flag = 1'b0;
                end
                else if (paddr == TDNV_OFF_IRQ_EN)
                begin
                    if (pstrb[0])
                        nxt_s.irq_en = pwdata[0];
                end
                else if (paddr != TDNV_OFF_TBLAT && paddr != TDNV_OFF_IRQ_STAT)
                    nxt_s.err = 1'b1;
            end
            else
            begin
                if (paddr == TDNV_OFF_TABLE_POINTER)
                    nxt_s.rdata = {10'h000, s_ff.table_pointer};
                else if (paddr == TDNV_OFF_TBLAT)
                    nxt_s.rdata = {24'h000000, s_ff.table_latch};
                else if (paddr == TDNV_OFF_CTRL)
                    nxt_s.rdata = {24'h000000, s_ff.eeprom_control};
                else if (paddr == TDNV_OFF_ADDR_LO)
                    nxt_s.rdata = {24'h000000, s_ff.eeprom_addr_low};
                else if (paddr == TDNV_OFF_ADDR_HI)
                    nxt_s.rdata = {24'h000000, s_ff.eeprom_addr_high};
                else if (paddr == TDNV_OFF_DATA)
                    nxt_s.rdata = {24'h000000, s_ff.eeprom_data_reg};
                else if (paddr == TDNV_OFF_IRQ_STAT)
                    nxt_s.rdata = {31'h00000000, s_ff.eeprom_done_flag};
                else if (paddr == TDNV_OFF_IRQ_EN)
                    nxt_s.rdata = {31'h00000000, s_ff.irq_en};
                else if (paddr == TDNV_OFF_UNLOCK || paddr == TDNV_OFF_TBLCMD
                         || paddr == TDNV_OFF_IRQ_CLR)
                    nxt_s.rdata = TDNV_ZERO32;
                else
                    nxt_s.err = 1'b1;
            end
        end

        // Post-adjust of the pointer once the fetch has used it
        if (s_ff.st == TDNV_S_TBL && tbl_mode_ff != TDNV_TM_PRE_INC)
            nxt_s.table_pointer = ptr_step(s_ff.table_pointer, tbl_mode_ff);
    end

    // ****************************************
    // State registers; clk_en low holds every bit
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff        <= '0;
            tbl_mode_ff <= TDNV_TM_NONE;
        end
        else if (clk_en)
        begin
            s_ff        <= nxt_s;
            tbl_mode_ff <= nxt_tbl_mode;
        end
    end
endmodule

//--- tdnv_top_asserts.sv
// Port checker for the table-read and EEPROM access block.
// Assumes it is bound to tdnv_top and sees only its ports.
`timescale 1ns/10ps
module tdnv_top_asserts
    import tdnv_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    // ****************************************
    // Bus answer timing and data
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Access taken on the first access edge, answered one cycle on
    a_ready_after_take: assert property (psel && penable && clk_en && !pready |=> pready)
        else $error("pready missing after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    a_err_map: assert property (pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > TDNV_OFF_IRQ_EN))
        else $error("pslverr does not match map");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // Read data only valid with pready, zero otherwise
    a_rdata_idle: assert property (!pready |-> prdata == TDNV_ZERO32)
        else $error("prdata not zero when idle");
    a_unlock_zero: assert property (pready && !pwrite && paddr == TDNV_OFF_UNLOCK
        |-> prdata == TDNV_ZERO32)
        else $error("unlock port read not zero");
    // Flag is sticky: irq drops only after a clear or enable write
    a_irq_sticky: assert property ($fell(irq) |-> $past(psel && penable && pwrite
        && (paddr == TDNV_OFF_IRQ_CLR || paddr == TDNV_OFF_IRQ_EN)))
        else $error("irq dropped without software");
    a_stat_shape: assert property (pready && !pwrite && paddr == TDNV_OFF_IRQ_STAT
        |-> prdata[31:1] == 31'h0 && (prdata[0] || !$past(irq)))
        else $error("status read inconsistent");

    // ****************************************
    // Coverage
    // ****************************************
    c_unmapped: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_key: cover property (psel && penable && pwrite && paddr == TDNV_OFF_UNLOCK);
endmodule

bind tdnv_top tdnv_top_asserts chk_u (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .pstrb   (pstrb),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .irq     (irq)
);

//--- tdnv_flash_model.sv
// Reference image of the program flash contents.
// Assumes the bench copies it into the flash array after reset.
`timescale 1ns/10ps
module tdnv_flash_model;
    // ****************************************
    // Byte image, one entry per byte address
    // ****************************************
    logic [7:0] img [0:15];

    // Every byte differs, so a byte from the wrong address shows up
    initial
    begin
        for (int i = 0; i < 16; i++)
            img[i] = 8'hA0 ^ (8'(i) * 8'h0B);
    end
endmodule

//--- tdnv_tb_top.sv
// Self-checking bench for the table-read and EEPROM access block.
// Assumes flash array u_pm holds one byte per pointer value in mem[].
`timescale 1ns/10ps
module tdnv_tb_top
    import tdnv_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        clk_en;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    int          err_total;
    int          checks;

    // ****************************************
    // Clock, design and flash image
    // ****************************************
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // Long write time so locked writes land mid-cycle
    tdnv_top #(.WRITE_CYC(40)) dut_u (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );
    tdnv_flash_model flash_u ();

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Request held until pready is sampled high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, TDNV_ZERO32);
        chk(rd, e);
    endtask

    task automatic test_done();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdx(TDNV_OFF_CTRL, {24'h0, TDNV_CTRL_RST});
        rdx(TDNV_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 8'h2C, TDNV_ZERO32);
        chk({31'h0, er}, 32'h1);
        $display("test reset done");
    endtask

    // All pointer modes, then an odd start crossing a word
    task automatic t_table();
        logic [7:0]  eb;
        logic [21:0] ep;
        for (int m = 0; m < 4; m++)
        begin
            ep = (m == 2) ? 22'h3 : ((m == 0) ? 22'h4 : 22'h5);
            eb = (m == 3) ? flash_u.img[5] : flash_u.img[4];
            wr(TDNV_OFF_TABLE_POINTER, 32'h4);
            wr(TDNV_OFF_TBLCMD, {29'h0, 2'(m), 1'b1});
            rdx(TDNV_OFF_TBLAT, {24'h0, eb});
            rdx(TDNV_OFF_TABLE_POINTER, {10'h0, ep});
        end
        wr(TDNV_OFF_TABLE_POINTER, 32'h7);
        for (int k = 7; k < 9; k++)
        begin
            wr(TDNV_OFF_TBLCMD, {29'h0, TDNV_TM_POST_INC, 1'b1});
            rdx(TDNV_OFF_TBLAT, {24'h0, flash_u.img[k]});
        end
        rdx(TDNV_OFF_TBLAT, {24'h0, flash_u.img[8]});
        $display("test table done");
    endtask

    task automatic t_write();
        wr(TDNV_OFF_IRQ_EN, 32'h1);
        wr(TDNV_OFF_ADDR_HI, 32'h1);
        wr(TDNV_OFF_ADDR_LO, 32'h23);
        wr(TDNV_OFF_DATA, 32'hC6);
        wr(TDNV_OFF_CTRL, 32'h4);
        wr(TDNV_OFF_UNLOCK, {24'h0, TDNV_KEY1});
        wr(TDNV_OFF_UNLOCK, {24'h0, TDNV_KEY2});
        wr(TDNV_OFF_CTRL, 32'h6);
        rdx(TDNV_OFF_CTRL, 32'h6);
        wr(TDNV_OFF_DATA, 32'h11);
        wr(TDNV_OFF_CTRL, 32'h0);
        rdx(TDNV_OFF_CTRL, 32'h6);
        for (int i = 0; i < 40 && rd[0] !== 1'b1; i++)
            apb(1'b0, TDNV_OFF_IRQ_STAT, TDNV_ZERO32);
        chk({31'h0, irq}, 32'h1);
        rdx(TDNV_OFF_CTRL, 32'h4);
        rdx(TDNV_OFF_DATA, 32'hC6);
        wr(TDNV_OFF_IRQ_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdx(TDNV_OFF_IRQ_STAT, 32'h1);
        wr(TDNV_OFF_IRQ_EN, 32'h1);
        wr(TDNV_OFF_IRQ_CLR, 32'h1);
        rdx(TDNV_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test write done");
    endtask

    task automatic t_read();
        wr(TDNV_OFF_DATA, 32'h0);
        wr(TDNV_OFF_CTRL, 32'h1);
        rdx(TDNV_OFF_DATA, 32'hC6);
        rdx(TDNV_OFF_DATA, 32'hC6);
        wr(TDNV_OFF_DATA, 32'h5A);
        wr(TDNV_OFF_CTRL, 32'h81);
        rdx(TDNV_OFF_DATA, 32'h5A);
        $display("test read done");
    endtask

    // Swapped keys, a write between keys, enable with start, no enable
    task automatic t_guard();
        for (int s = 0; s < 4; s++)
        begin
            wr(TDNV_OFF_CTRL, (s == 1 || s == 2) ? 32'h4 : 32'h0);
            wr(TDNV_OFF_UNLOCK, {24'h0, (s == 1) ? TDNV_KEY2 : TDNV_KEY1});
            if (s == 2)
                wr(TDNV_OFF_DATA, 32'h77);
            wr(TDNV_OFF_UNLOCK, {24'h0, (s == 1) ? TDNV_KEY1 : TDNV_KEY2});
            wr(TDNV_OFF_CTRL, (s == 3) ? 32'h2 : 32'h6);
            rdx(TDNV_OFF_CTRL, (s == 3) ? 32'h0 : 32'h4);
        end
        rdx(TDNV_OFF_UNLOCK, 32'h0);
        wr(TDNV_OFF_CTRL, 32'h1);
        rdx(TDNV_OFF_DATA, 32'hC6);
        $display("test guard done");
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        err_total = 0;
        checks    = 0;
        presetn   = 1'b0;
        clk_en    = 1'b1;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h0;
        pstrb     = 4'h1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 16; i++)
            dut_u.u_pm.mem[i] = flash_u.img[i];
        t_reset();
        t_table();
        t_write();
        t_read();
        t_guard();
        test_done();
    end

    // Whole run is about 330 cycles; this cuts a hung handshake
    initial
    begin
        repeat (5000) @(posedge pclk);
        err_total++;
        test_done();
    end
endmodule
